// ==== rtl/fault_guard_consts.svh ====
/*
  Constants of the supply fault and shoot-through guard: register
  offsets, field positions, reset values and timing figures.
  Assumes inclusion by bare name from the design file and the bench.
*/
`ifndef FAULT_GUARD_CONSTS_SVH
`define FAULT_GUARD_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------
`define OFS_ERR 8'h00
`define OFS_CTRL 8'h04
`define OFS_CFG 8'h08
`define OFS_STAT 8'h0C

// ----------------------------------------------------------------------
// Error register fields (write one to clear)
// ----------------------------------------------------------------------
`define ERR_PRIM_RST 0
`define ERR_POS_UV 1
`define ERR_POS_OV 2
`define ERR_NEG_UV 3
`define ERR_NEG_OV 4
`define ERR_OV_TMO 5
`define ERR_ST 6
`define ERR_W 7

// ----------------------------------------------------------------------
// Control, configuration and status fields
// ----------------------------------------------------------------------
`define CTRL_SEL 0
`define CTRL_REF 1
`define CFG_NEG_OV_DIS 0
`define CFG_RESET 1'b1
`define STAT_W 10

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 50
`define DEAD_TIME_NS 200
`define ST_FILTER_NS 50
`define DEAD_CYC ((`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILT_CYC ((`ST_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WDOG_LIMIT_DEFAULT 65535

`endif

// ==== rtl/fault_guard_pkg.sv ====
/*
  Types of the supply fault and shoot-through guard.
  Assumes nothing of its surroundings.
*/
package fault_guard_pkg;

    // Counterpart tracking for the shoot-through guard
    typedef enum logic [1:0] {
        ST_ARMED,
        ST_INHIBIT,
        ST_DEAD
    } st_state_t;

    typedef logic [31:0] apb_word_t;

endpackage : fault_guard_pkg

// ==== rtl/supply_fault_and_shoot_through_guard.sv ====
/*
  Supply fault logic and shoot-through guard of an isolated gate driver,
  with an APB register slave for flags, control and live status.
  Assumes comparator levels and PWM inputs arrive asynchronously and are
  synchronised here; the APB master follows the usual two-phase protocol.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fault_guard_consts.svh"

// Overview of operation
// R01 - Primary undervoltage starts regular turn-off and pulls reset/ready low.
// R02 - Primary recovery releases reset/ready and sets primary-reset flag.
// R03 - Positive secondary undervoltage: turn-off, error flag, fault output.
// R04 - Positive secondary overvoltage: turn-off, error flag, fault output.
// R05 - Active selection 0 gives class B reaction, 1 gives class C.
// R06 - Software select and refresh bits are mirrored to secondary copies.
// R07 - Active selection sets only when mirrored select and refresh are set.
// R08 - Active selection clears on mirrored select low or watchdog timeout.
// R09 - Rising active selection resets watchdog; it counts while set.
// R10 - Refresh bit rising edge resets the watchdog timer.
// R11 - Watchdog overflow clears active selection and sets timeout flag.
// R12 - Negative secondary undervoltage: turn-off, error flag, fault output.
// R13 - Negative overvoltage acts only while its disable bit is zero.
// R14 - Negative overvoltage disable bit resets to one.
// R15 - Live monitor status bits readable apart from latched flags.
// R16 - Positive secondary below reset threshold holds secondary logic reset.
// R17 - Counterpart on inhibits own PWM, plus fixed minimum dead time.
// R18 - PWM on during inhibition is ignored and sets shoot-through flag.
// R19 - Violations shorter than about 50 ns do not set the flag; the code sets it on a violation seen at one clock sample.
// R20 - No disable; during power-up PWM activity sets flag, blocks turn-on.
// R21 - Host does normal dead-time management; guard is only a backup.
// R22 - Comparator and counterpart inputs are synchronised before use.
module supply_fault_and_shoot_through_guard #(
    parameter int unsigned WDOG_LIMIT = `WDOG_LIMIT_DEFAULT
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire fault_guard_pkg::apb_word_t pwdata,
    output fault_guard_pkg::apb_word_t prdata,
    output logic pready,
    output logic pslverr,
    input wire logic prim_undervolt_cmp,
    input wire logic pos_below_reset_cmp,
    input wire logic pos_undervolt_cmp,
    input wire logic pos_overvolt_cmp,
    input wire logic neg_undervolt_cmp,
    input wire logic neg_overvolt_cmp,
    input wire logic pwm_in_pos,
    input wire logic counterpart_pwm_in,
    output logic reset_ready_n_out,
    output logic supply_fault_n_out,
    output logic regular_turn_off,
    output logic ov_reaction_class_c,
    output logic pwm_gated_out
);
    import fault_guard_pkg::*;

    localparam logic [3:0] DEAD_CYC = 4'(`DEAD_CYC);
    localparam logic [3:0] FILT_CYC = 4'(`FILT_CYC);
    localparam logic [15:0] WDOG_MAX = 16'(WDOG_LIMIT);

    // ------------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    // Async assert, release through two flops so all logic leaves together
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else if (clk_en) begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    logic [7:0] raw_in;
    logic [7:0] meta_q;
    logic [7:0] sync_q;
    assign raw_in = {counterpart_pwm_in, pwm_in_pos, neg_overvolt_cmp,
                     neg_undervolt_cmp, pos_overvolt_cmp, pos_undervolt_cmp,
                     pos_below_reset_cmp, prim_undervolt_cmp};

    // Two flops per input; only the second stage is used downstream
    for (genvar i = 0; i < 8; i++) begin : g_sync
        always_ff @(posedge clk or negedge rst_n_q) begin
            if (!rst_n_q) begin
                meta_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
            end else if (clk_en) begin
                meta_q[i] <= raw_in[i]; // R22
                sync_q[i] <= meta_q[i]; // R22
            end
        end
    end

    logic s_prim_uv, s_sec_rst, s_pos_uv, s_pos_ov;
    logic s_neg_uv, s_neg_ov, s_pwm, s_cp;
    assign {s_cp, s_pwm, s_neg_ov, s_neg_uv, s_pos_ov, s_pos_uv, s_sec_rst,
            s_prim_uv} = sync_q;

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    logic [`ERR_W-1:0] err_q;
    logic [1:0] ctrl_q;
    logic cfg_q;
    logic [`STAT_W-1:0] stat;
    logic sel_mirror_q, ref_mirror_q, active_q;
    logic wr_en, mapped;
    apb_word_t rd_word;

    assign wr_en = psel && penable && pready && pwrite;
    assign mapped = (paddr == `OFS_ERR) || (paddr == `OFS_CTRL) ||
                    (paddr == `OFS_CFG) || (paddr == `OFS_STAT);

    // Read mux; unmapped and reserved bits read as zero
    always_comb begin
        rd_word = '0;
        case (paddr)
            `OFS_ERR: rd_word[`ERR_W-1:0] = err_q;
            `OFS_CTRL: rd_word[1:0] = ctrl_q;
            `OFS_CFG: rd_word[0] = cfg_q;
            `OFS_STAT: rd_word[`STAT_W-1:0] = stat;
            default: rd_word = '0;
        endcase
    end

    // One access cycle, answer registered in the setup cycle
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (clk_en) begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable && !pwrite) ? rd_word : '0;
        end
    end

    // Control and configuration registers
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q <= 2'h0;
            cfg_q <= `CFG_RESET; // R14
        end else if (clk_en && wr_en) begin
            if (paddr == `OFS_CTRL)
                ctrl_q <= pwdata[1:0];
            if (paddr == `OFS_CFG)
                cfg_q <= pwdata[`CFG_NEG_OV_DIS];
        end
    end

    // ------------------------------------------------------------------
    // Supply fault reaction
    // ------------------------------------------------------------------
    logic neg_ov_act;
    logic [4:0] cond;
    logic [4:0] cond_prev_q;
    logic [`ERR_W-1:0] err_set, err_clr;
    logic wd_timeout;
    logic viol_hit, st_inhibit;

    assign neg_ov_act = s_neg_ov && !cfg_q; // R13
    // Secondary monitors count only while secondary logic is out of reset
    assign cond = {s_prim_uv,
                   !s_sec_rst && s_pos_uv, // R03
                   !s_sec_rst && s_pos_ov, // R04
                   !s_sec_rst && s_neg_uv, // R12
                   !s_sec_rst && neg_ov_act}; // R13

    // Live status beside the latched flags
    assign stat = {!reset_ready_n_out, !supply_fault_n_out, ref_mirror_q,
                   sel_mirror_q, active_q, s_pwm && st_inhibit,
                   s_neg_ov, s_neg_uv, s_pos_ov, s_pos_uv}; // R15

    assign err_set = {viol_hit, wd_timeout, cond[0], cond[1], cond[2],
                      cond[3], cond_prev_q[4] && !s_prim_uv};
    assign err_clr = (wr_en && paddr == `OFS_ERR) ?
                     pwdata[`ERR_W-1:0] : '0;

    // Sticky flags: a set in the clearing cycle wins over the clear
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            err_q <= '0;
        end else if (clk_en) begin
            err_q <= (err_q & ~err_clr) | err_set; // R02 R03 R04 R12 R13
            if (s_sec_rst)
                err_q[`ERR_NEG_OV:`ERR_POS_UV] <= 4'h0; // R16
        end
    end

    // Turn-off pulse on the onset of any fault, pins follow the condition
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cond_prev_q <= 5'h0;
            regular_turn_off <= 1'b0;
            reset_ready_n_out <= 1'b0;
            supply_fault_n_out <= 1'b1;
            ov_reaction_class_c <= 1'b0;
        end else if (clk_en) begin
            cond_prev_q <= cond;
            regular_turn_off <= |(cond & ~cond_prev_q); // R01 R03 R04 R12
            reset_ready_n_out <= !s_prim_uv; // R01 R02
            supply_fault_n_out <= !(|cond[3:0]); // R03 R04 R12 R13
            ov_reaction_class_c <= active_q; // R05
        end
    end

    // ------------------------------------------------------------------
    // Overvoltage reaction selection and watchdog
    // ------------------------------------------------------------------
    logic ref_prev_q, active_prev_q, lock_q;
    logic [15:0] wd_cnt_q;
    logic ref_rise;

    assign ref_rise = ref_mirror_q && !ref_prev_q;
    assign wd_timeout = active_q && (wd_cnt_q == WDOG_MAX);

    // Mirrors and active selection; a timeout locks out re-selection
    // until the next refresh edge, else it would re-arm at once
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sel_mirror_q <= 1'b0;
            ref_mirror_q <= 1'b0;
            ref_prev_q <= 1'b0;
            active_q <= 1'b0;
            active_prev_q <= 1'b0;
            lock_q <= 1'b0;
        end else if (clk_en) begin
            if (s_sec_rst) begin
                sel_mirror_q <= 1'b0; // R16
                ref_mirror_q <= 1'b0;
                ref_prev_q <= 1'b0;
                active_q <= 1'b0;
                active_prev_q <= 1'b0;
                lock_q <= 1'b0;
            end else begin
                sel_mirror_q <= ctrl_q[`CTRL_SEL]; // R06
                ref_mirror_q <= ctrl_q[`CTRL_REF]; // R06
                ref_prev_q <= ref_mirror_q;
                active_prev_q <= active_q;
                if (wd_timeout)
                    lock_q <= 1'b1;
                else if (ref_rise)
                    lock_q <= 1'b0;
                if (!sel_mirror_q || wd_timeout)
                    active_q <= 1'b0; // R08 R11
                else if (sel_mirror_q && ref_mirror_q && !lock_q)
                    active_q <= 1'b1; // R07
            end
        end
    end

    // Watchdog counts while selected, restarts on select or refresh edge
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wd_cnt_q <= 16'h0000;
        end else if (clk_en) begin
            if (!active_q || s_sec_rst)
                wd_cnt_q <= 16'h0000;
            else if (!active_prev_q || ref_rise)
                wd_cnt_q <= 16'h0000; // R09 R10
            else if (wd_cnt_q != WDOG_MAX)
                wd_cnt_q <= wd_cnt_q + 16'h0001; // R09
        end
    end

    // ------------------------------------------------------------------
    // Shoot-through guard (no disable; host keeps its own dead time)
    // ------------------------------------------------------------------
    st_state_t st_q;
    logic [3:0] dead_q, filt_q;
    logic block_q, power_up, viol;

    // Before supplies are good any PWM activity counts as a violation
    assign power_up = s_prim_uv || s_sec_rst; // R20
    assign st_inhibit = (st_q != ST_ARMED) || s_cp || power_up; // R17
    assign viol = s_pwm && st_inhibit;
    // Widened so a saturated filter count cannot wrap and drop the flag
    assign viol_hit = viol && ({1'b0, filt_q} + 5'h01 >= {1'b0, FILT_CYC}); // R19

    // Counterpart tracking with the fixed dead time after it goes off
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q <= ST_ARMED;
            dead_q <= 4'h0;
        end else if (clk_en) begin
            case (st_q)
                ST_ARMED: if (s_cp) st_q <= ST_INHIBIT; // R17
                ST_INHIBIT: if (!s_cp) begin
                    st_q <= ST_DEAD;
                    dead_q <= DEAD_CYC - 4'h1;
                end
                ST_DEAD: begin
                    if (s_cp)
                        st_q <= ST_INHIBIT;
                    else if (dead_q == 4'h0)
                        st_q <= ST_ARMED;
                    else
                        dead_q <= dead_q - 4'h1; // R17
                end
                default: st_q <= ST_ARMED;
            endcase
        end
    end

    // An on level raised while inhibited is ignored until it drops
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            block_q <= 1'b0;
            filt_q <= 4'h0;
            pwm_gated_out <= 1'b0;
        end else if (clk_en) begin
            filt_q <= viol ? ((filt_q == 4'hF) ? filt_q : filt_q + 4'h1)
                           : 4'h0; // R19
            if (!s_pwm)
                block_q <= 1'b0;
            else if (st_inhibit)
                block_q <= 1'b1; // R18
            pwm_gated_out <= s_pwm && !st_inhibit && !block_q; // R17 R18
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_q || !clk_en);

    property p_prim_uv;
        $rose(s_prim_uv) |=> regular_turn_off && !reset_ready_n_out;
    endproperty
    a_prim_uv: assert property (p_prim_uv) // R01
        else $error("primary undervoltage reaction missing");

    property p_prim_rec;
        $fell(s_prim_uv) |=> err_q[`ERR_PRIM_RST] && reset_ready_n_out;
    endproperty
    a_prim_rec: assert property (p_prim_rec) // R02
        else $error("primary recovery not flagged");

    property p_pos_uv;
        $rose(s_pos_uv) && !s_sec_rst |=>
            err_q[`ERR_POS_UV] && regular_turn_off && !supply_fault_n_out;
    endproperty
    a_pos_uv: assert property (p_pos_uv) // R03
        else $error("positive undervoltage reaction missing");

    property p_pos_ov;
        $rose(s_pos_ov) && !s_sec_rst |=>
            err_q[`ERR_POS_OV] && !supply_fault_n_out;
    endproperty
    a_pos_ov: assert property (p_pos_ov) // R04
        else $error("positive overvoltage reaction missing");

    property p_sel_clear;
        !sel_mirror_q |=> !active_q ##1 !ov_reaction_class_c;
    endproperty
    a_sel_clear: assert property (p_sel_clear) // R08
        else $error("selection not cleared");

    property p_timeout;
        wd_timeout && !s_sec_rst |=> !active_q && err_q[`ERR_OV_TMO];
    endproperty
    a_timeout: assert property (p_timeout) // R11
        else $error("watchdog timeout not handled");

    property p_neg_ov_dis;
        cfg_q && !s_pos_uv && !s_pos_ov && !s_neg_uv |=> supply_fault_n_out;
    endproperty
    a_neg_ov_dis: assert property (p_neg_ov_dis) // R13
        else $error("disabled negative overvoltage raised fault");

    property p_sec_rst;
        s_sec_rst |=> !active_q && !sel_mirror_q && err_q[4:1] == 4'h0;
    endproperty
    a_sec_rst: assert property (p_sec_rst) // R16
        else $error("secondary logic not held in reset");

    property p_cp_block;
        s_cp |=> !pwm_gated_out;
    endproperty
    a_cp_block: assert property (p_cp_block) // R17
        else $error("PWM passed while counterpart on");

    property p_ignore;
        s_pwm && st_inhibit |=> err_q[`ERR_ST] ##1 !pwm_gated_out;
    endproperty
    a_ignore: assert property (p_ignore) // R18
        else $error("violating PWM not ignored");

    c_timeout: cover property (wd_timeout);
    c_active: cover property ($rose(active_q));
    c_shoot: cover property ($rose(err_q[`ERR_ST]));
    c_prim_rec: cover property ($fell(s_prim_uv));

endmodule : supply_fault_and_shoot_through_guard
`default_nettype wire

// ==== verification/counterpart_driver_model.sv ====
/*
  Behavioural model of the counterpart half-bridge driver as seen on
  the shoot-through input. Assumes the bench drives its command pins
  right after the rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module counterpart_driver_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic on_cmd,
    input wire logic rogue,
    input wire logic own_pwm,
    output logic counterpart_pwm_in
);
    // ------------------------------------------------------------------
    // Counterpart output stage
    // ------------------------------------------------------------------
    // Host interlock holds off turn-on while our own side is on; rogue
    // bypasses it to imitate an erroneous command from the host
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            counterpart_pwm_in <= 1'b0;
        end else begin
            counterpart_pwm_in <= on_cmd & (rogue | ~own_pwm);
        end
    end
endmodule : counterpart_driver_model
`default_nettype wire

// ==== verification/supply_fault_and_shoot_through_guard_test.sv ====
/*
  Self-checking bench of the supply fault and shoot-through guard:
  APB read and write tasks, comparator and PWM stimulus.
  Assumes the design package, constants header and counterpart model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fault_guard_consts.svh"
module supply_fault_and_shoot_through_guard_test;
    import fault_guard_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam int unsigned WDOG = 20;
    localparam int LIMIT = 20000;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    apb_word_t pwdata = 32'h0;
    apb_word_t prdata;
    logic pready, pslverr, rst_ready_n, fault_n, turn_off, class_c, pwm_out;
    logic prim_uv = 1'b0;
    logic below_rst = 1'b0;
    logic [3:0] cmp = 4'h0; // neg_ov, neg_uv, pos_ov, pos_uv
    logic pwm = 1'b0;
    logic cp_on = 1'b0;
    logic rogue = 1'b0;
    logic cp_pwm;
    apb_word_t rd;
    logic er;
    int bad_count = 0;
    int total_checks = 0;
    int pulses = 0;
    int p0;
    int cycles = 0;

    // ------------------------------------------------------------------
    // Clock, pulse counter and hang guard
    // ------------------------------------------------------------------
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (regular_turn_off_seen()) pulses <= pulses + 1;
        if (cycles == LIMIT) begin
            bad_count++;
            close_out();
        end
    end
    function automatic logic regular_turn_off_seen();
        return turn_off === 1'b1;
    endfunction : regular_turn_off_seen

    supply_fault_and_shoot_through_guard #(.WDOG_LIMIT(WDOG)) i_dut (
        .clk(clk), .reset_n(reset_n), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .prim_undervolt_cmp(prim_uv),
        .pos_below_reset_cmp(below_rst), .pos_undervolt_cmp(cmp[0]),
        .pos_overvolt_cmp(cmp[1]), .neg_undervolt_cmp(cmp[2]),
        .neg_overvolt_cmp(cmp[3]), .pwm_in_pos(pwm),
        .counterpart_pwm_in(cp_pwm), .reset_ready_n_out(rst_ready_n),
        .supply_fault_n_out(fault_n), .regular_turn_off(turn_off),
        .ov_reaction_class_c(class_c), .pwm_gated_out(pwm_out)
    );
    counterpart_driver_model i_cp (
        .clk(clk), .reset_n(reset_n), .on_cmd(cp_on), .rogue(rogue),
        .own_pwm(pwm), .counterpart_pwm_in(cp_pwm)
    );

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cyc
    // Holds the request until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input apb_word_t wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        wait_cyc(16);
        reset_n <= 1'b1;
        wait_cyc(6);
        apb(1'b0, `OFS_CFG, 32'h0);
        check("cfg_reset", rd, 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped_err", {31'h0, er}, 32'h1);
        // Primary undervoltage and recovery
        p0 = pulses;
        prim_uv <= 1'b1;
        wait_cyc(6);
        check("rdy_low", rst_ready_n, 1'b0);
        check("prim_pulse", pulses - p0, 1);
        prim_uv <= 1'b0;
        wait_cyc(6);
        check("rdy_high", rst_ready_n, 1'b1);
        apb(1'b0, `OFS_ERR, 32'h0);
        check("prim_flag", rd, 32'h1);
        apb(1'b1, `OFS_ERR, 32'h7F);
        // Negative overvoltage ignored while disabled by default
        cmp <= 4'h8;
        wait_cyc(6);
        check("negov_off_pin", fault_n, 1'b1);
        apb(1'b0, `OFS_ERR, 32'h0);
        check("negov_off_flag", rd, 32'h0);
        cmp <= 4'h0;
        apb(1'b1, `OFS_CFG, 32'h0);
        // Each secondary monitor in turn
        for (int i = 0; i < 4; i++) begin
            p0 = pulses;
            cmp <= 4'h1 << i;
            wait_cyc(6);
            check("sec_pin", fault_n, 1'b0);
            apb(1'b0, `OFS_STAT, 32'h0);
            check("sec_live", rd[3:0], 4'h1 << i);
            cmp <= 4'h0;
            wait_cyc(6);
            check("sec_pin_clear", fault_n, 1'b1);
            check("sec_pulse", pulses - p0, 1);
            apb(1'b0, `OFS_ERR, 32'h0);
            check("sec_flag", rd, 32'h2 << i);
            apb(1'b1, `OFS_ERR, 32'h7F);
        end
        // Secondary reset wipes the secondary flags
        cmp <= 4'h1;
        wait_cyc(6);
        below_rst <= 1'b1;
        wait_cyc(6);
        apb(1'b0, `OFS_ERR, 32'h0);
        check("sec_reset_flags", rd[4:1], 4'h0);
        cmp <= 4'h0;
        below_rst <= 1'b0;
        wait_cyc(6);
        // Overvoltage reaction selection with refresh, then timeout
        apb(1'b1, `OFS_CTRL, 32'h1);
        wait_cyc(4);
        check("sel_only", class_c, 1'b0);
        apb(1'b1, `OFS_CTRL, 32'h3);
        wait_cyc(4);
        check("class_c", class_c, 1'b1);
        apb(1'b0, `OFS_STAT, 32'h0);
        check("mirrors", rd[7:5], 3'h7);
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, `OFS_CTRL, 32'h1);
            apb(1'b1, `OFS_CTRL, 32'h3);
        end
        check("refreshed", class_c, 1'b1);
        wait_cyc(WDOG + 10);
        check("timed_out", class_c, 1'b0);
        apb(1'b0, `OFS_ERR, 32'h0);
        check("tmo_flag", rd, 32'h20);
        apb(1'b1, `OFS_ERR, 32'h7F);
        apb(1'b1, `OFS_CTRL, 32'h1);
        apb(1'b1, `OFS_CTRL, 32'h3);
        wait_cyc(5);
        check("reselect", class_c, 1'b1);
        apb(1'b1, `OFS_CTRL, 32'h2);
        wait_cyc(4);
        check("sel_cleared", class_c, 1'b0);
        // Shoot-through guard
        pwm <= 1'b1;
        wait_cyc(5);
        check("pwm_pass", pwm_out, 1'b1);
        cp_on <= 1'b1;
        rogue <= 1'b1;
        wait_cyc(5);
        check("pwm_inhibit", pwm_out, 1'b0);
        apb(1'b0, `OFS_STAT, 32'h0);
        check("st_status", rd[4], 1'b1);
        apb(1'b0, `OFS_ERR, 32'h0);
        check("st_flag", rd, 32'h40);
        pwm <= 1'b0;
        apb(1'b1, `OFS_ERR, 32'h7F);
        cp_on <= 1'b0;
        rogue <= 1'b0;
        wait_cyc(4);
        pwm <= 1'b1;
        wait_cyc(4);
        check("dead_block", pwm_out, 1'b0);
        wait_cyc(6);
        check("block_held", pwm_out, 1'b0);
        apb(1'b0, `OFS_ERR, 32'h0);
        check("dead_flag", rd, 32'h40);
        pwm <= 1'b0;
        wait_cyc(4);
        pwm <= 1'b1;
        wait_cyc(5);
        check("pwm_resume", pwm_out, 1'b1);
        // Supply drop with PWM still on counts as a violation
        apb(1'b1, `OFS_ERR, 32'h7F);
        prim_uv <= 1'b1;
        wait_cyc(6);
        check("pu_block", pwm_out, 1'b0);
        apb(1'b0, `OFS_ERR, 32'h0);
        check("pu_flag", rd, 32'h40);
        close_out();
    end
endmodule : supply_fault_and_shoot_through_guard_test
`default_nettype wire
